// *** smbus_engine_monitor.sv ***
// Checker for the two-wire transaction engine, bound to its top ports.
// Assumes one clock domain and the engine's synchronous active-high reset.
`timescale 1ns/1ps
module smbus_engine_monitor
  import smbus_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic scl_oe_n,
  input wire logic sda_in,
  input wire logic sda_oe_n,
  input wire logic cmd_valid,
  input wire logic cmd_ready,
  input wire logic rx_valid,
  input wire logic bus_busy,
  input wire logic master_active,
  input wire logic done,
  input wire logic arb_lost,
  input wire logic nack,
  input wire logic status_clr
);
  logic [15:0] hi_cnt_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Cycles SCL has read high while released; saturates so long idle never wraps
  always_ff @(posedge clk) begin
    if (rst || !scl_in || !scl_oe_n) hi_cnt_q <= 16'h0000;
    else if (hi_cnt_q != 16'hffff) hi_cnt_q <= hi_cnt_q + 16'h0001;
  end

  property p_start_after_take;
    cmd_valid && cmd_ready |-> ##[2:3] (!sda_oe_n && scl_in);
  endproperty
  a_start_after_take: assert property (p_start_after_take)
    else $error("no start condition after command");
  property p_ready_drops;
    cmd_valid && cmd_ready |=> !cmd_ready;
  endproperty
  a_ready_drops: assert property (p_ready_drops)
    else $error("command ready stayed high after take");
  property p_ready_free;
    cmd_ready |-> !bus_busy && !master_active;
  endproperty
  a_ready_free: assert property (p_ready_free)
    else $error("command ready while bus busy");
  property p_high_phase;
    master_active && $fell(scl_oe_n) |-> hi_cnt_q >= 16'(SCL_HIGH_CYC);
  endproperty
  a_high_phase: assert property (p_high_phase)
    else $error("clock pulled low before full high phase");
  property p_nack_sticky;
    nack && !status_clr |=> nack;
  endproperty
  a_nack_sticky: assert property (p_nack_sticky)
    else $error("nack flag lost without clear");
  property p_arb_release;
    $rose(arb_lost) |-> ##[0:1] (sda_oe_n && scl_oe_n);
  endproperty
  a_arb_release: assert property (p_arb_release)
    else $error("bus still driven after arbitration loss");
  property p_arb_cause;
    $rose(arb_lost) |-> $past(master_active);
  endproperty
  a_arb_cause: assert property (p_arb_cause)
    else $error("arbitration loss without own transfer");
  property p_rx_pulse;
    rx_valid |=> !rx_valid [*8];
  endproperty
  a_rx_pulse: assert property (p_rx_pulse)
    else $error("receive strobe too long or too dense");
  property p_done_free;
    done |-> (scl_oe_n && scl_in) ##1 (sda_oe_n && sda_in);
  endproperty
  a_done_free: assert property (p_done_free)
    else $error("done while bus not released");
  property p_scl_master_only;
    !master_active && !$past(master_active) |-> scl_oe_n;
  endproperty
  a_scl_master_only: assert property (p_scl_master_only)
    else $error("clock driven while not master");
endmodule

bind smbus_transaction_engine smbus_engine_monitor u_smbus_engine_monitor (
  .clk(clk), .rst(rst), .scl_in(scl_in), .scl_oe_n(scl_oe_n), .sda_in(sda_in),
  .sda_oe_n(sda_oe_n), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .rx_valid(rx_valid),
  .bus_busy(bus_busy), .master_active(master_active), .done(done), .arb_lost(arb_lost),
  .nack(nack), .status_clr(status_clr)
);

// *** smbus_partner_model.sv ***
// Behavioural slave standing on the far side of the two-wire bus.
// Assumes resolved wire levels with pull-ups; pulls are active high here.
`timescale 1ns/1ps
module smbus_partner_model #(
  parameter logic [6:0] ADDR = 7'h2c,
  parameter logic [7:0] DATA = 8'ha5
) (
  input  wire logic  scl,
  input  wire logic  sda,
  input  wire logic  stretch,
  output logic       scl_pull,
  output logic       sda_pull,
  output logic [7:0] got_addr,
  output logic [7:0] got_data,
  output logic       got_mack
);
  logic       on;
  logic       rd;
  logic       aph;
  logic [3:0] bitn;
  logic [7:0] sh;

  initial begin
    {on, rd, aph, scl_pull, sda_pull, got_mack} = 6'h00;
    {bitn, sh, got_addr, got_data} = 28'h0;
  end
  // Start: data falls while clock high; stop frees our pull
  always @(negedge sda) if (scl === 1'b1) begin
    {aph, on, rd} = 3'b110;
    bitn = 4'hf;  // The START's own clock fall wraps this to bit 0
  end
  always @(posedge sda) if (scl === 1'b1) begin
    on = 1'b0;
    sda_pull = 1'b0;
  end
  // Sample on rising clock, MSB first, then the acknowledge slot
  always @(posedge scl) if (on) begin
    if (bitn < 4'h8) sh = {sh[6:0], sda};
    else if (rd) got_mack = sda;
  end
  // Hold 100 ns after the fall so data never moves while the clock is high
  always @(negedge scl) if (on) begin
    #100;
    if (bitn == 4'h7) begin
      if (aph) begin
        on = (sh[7:1] == ADDR);  // Direction in bit 0
        rd = sh[0];
        got_addr = sh;
        aph = 1'b0;
        sda_pull = on;  // Acknowledge own address
      end else begin
        if (!rd) got_data = sh;
        sda_pull = !rd;  // Acknowledge written bytes
      end
      bitn = 4'h8;
    end else if (bitn == 4'h8) begin
      bitn = 4'h0;
      if (rd && got_mack) on = 1'b0;  // Master refused: stop sending
      sda_pull = rd && on && !DATA[7];
    end else begin
      bitn = bitn + 4'h1;
      sda_pull = rd && !DATA[7 - bitn];  // Read data MSB first
    end
  end
  // Clock-low extension past the master's own low time
  always @(negedge scl) if (on && stretch) begin
    scl_pull = 1'b1;
    #6000;
    scl_pull = 1'b0;
  end
endmodule

// *** smbus_pkg.sv ***
// Constants, timing and state encodings for the two-wire transaction engine.
// Assumes a single 200 MHz system clock; all times are converted to cycles here.
package smbus_pkg;
  localparam int CLK_PERIOD_NS  = 5;
  // Bus timing in ns (least times, rounded up to whole cycles)
  localparam int SCL_LOW_NS     = 4700;
  localparam int SCL_HIGH_NS    = 4000;
  localparam int START_HOLD_NS  = 4000;
  localparam int STOP_SETUP_NS  = 4000;
  localparam int BUS_FREE_NS    = 50000;
  localparam int SCL_LOW_CYC    = (SCL_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SCL_HIGH_CYC   = (SCL_HIGH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int START_HOLD_CYC = (START_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STOP_SETUP_CYC = (STOP_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BUS_FREE_CYC   = (BUS_FREE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TCNT_W         = 11;
  // Byte framing: 7 address bits, direction in bit 0, then an acknowledge slot
  localparam int ADDR_BITS      = 7;
  localparam int DATA_BITS      = 8;
  localparam logic [3:0] SLOT_ACK = 4'h8;
  localparam logic [3:0] SLOT_END = 4'h9;
  localparam logic DIR_READ     = 1'b1;
  localparam logic DIR_WRITE    = 1'b0;
  typedef enum logic [2:0] {
    M_IDLE      = 3'b000,
    M_START     = 3'b001,
    M_LOW       = 3'b010,
    M_HIGH      = 3'b011,
    M_STOP_LOW  = 3'b100,
    M_STOP_HIGH = 3'b101
  } mstate_e;
  typedef enum logic [1:0] {
    PH_IDLE  = 2'b00,
    PH_ADDR  = 2'b01,
    PH_WRITE = 2'b10,
    PH_READ  = 2'b11
  } phase_e;
endpackage

// *** smbus_transaction_engine.sv ***
// Two-wire bus transaction engine: master and slave, with write-data FIFO.
// Assumes open-drain SCL/SDA resolved outside; pins are asynchronous to clk.
// Contract
// - Frame is START, address byte with direction in bit 0, data bytes, STOP.
// - Receiver acknowledges each byte by holding SDA low while SCL is high; as master the engine leaves the last read byte unacknowledged.
// - SDA high in the acknowledge slot is read as not-acknowledge.
// - Direction bit one requests a read, zero requests a write.
// - Only a master issues START then sends address and direction.
// - Master writes bytes one at a time, awaiting slave acknowledge each.
// - In reads the slave sends bytes, awaiting master acknowledge each.
// - Master ends the transaction with STOP after its last byte.
// - Master starts only on a free bus: after STOP or long idle high.
// - Master sending high but seeing SDA low has lost arbitration; the engine checks only address and write data bits.
// - Winner continues; loser turns slave and receives if addressed.
// - A slave may hold SCL low to lengthen the low phase.
`timescale 1ns/1ps

module smbus_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] in_data,
  input  wire logic         in_valid,
  output logic              in_ready,
  output logic [W-1:0]      out_data,
  output logic              out_valid,
  input  wire logic         out_ready
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH) $error("fifo depth must be a power of two");
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q, rd_q;
  logic [AW:0]   cnt_q;
  logic          push, pop;
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;
  assign out_valid = (cnt_q != '0);
  assign out_data  = mem[rd_q];
  // Pointers and fill level; ready is a flop so the source sees honest back-pressure
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_q     <= '0;
      rd_q     <= '0;
      cnt_q    <= '0;
      in_ready <= 1'b0;
    end else begin
      if (push) wr_q <= wr_q + 1'b1;
      if (pop) rd_q <= rd_q + 1'b1;
      cnt_q    <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      in_ready <= (cnt_q + (AW+1)'(push) - (AW+1)'(pop)) < (AW+1)'(DEPTH);
    end
  end
  // Storage
  always_ff @(posedge clk) begin
    if (push) mem[wr_q] <= in_data;
  end
endmodule

module smbus_transaction_engine #(
  parameter int BUS_FREE_CYC = smbus_pkg::BUS_FREE_CYC,
  parameter int FIFO_DEPTH   = 16
) (
  input  wire logic                       clk,
  input  wire logic                       rst,
  input  wire logic                       scl_in,
  output logic                            scl_out,
  output logic                            scl_oe_n,
  input  wire logic                       sda_in,
  output logic                            sda_out,
  output logic                            sda_oe_n,
  input  wire logic                       cmd_valid,
  output logic                            cmd_ready,
  input  wire logic [smbus_pkg::ADDR_BITS-1:0] cmd_addr,
  input  wire logic                       cmd_rw,
  input  wire logic [7:0]                 cmd_len,
  input  wire logic [smbus_pkg::DATA_BITS-1:0] tx_data,
  input  wire logic                       tx_valid,
  output logic                            tx_ready,
  input  wire logic [smbus_pkg::ADDR_BITS-1:0] own_addr,
  input  wire logic [smbus_pkg::DATA_BITS-1:0] slv_tx_data,
  output logic [smbus_pkg::DATA_BITS-1:0] rx_data,
  output logic                            rx_valid,
  output logic                            rx_as_master,
  output logic                            bus_busy,
  output logic                            master_active,
  output logic                            done,
  output logic                            arb_lost,
  output logic                            nack,
  input  wire logic                       status_clr
);
  import smbus_pkg::*;
  localparam int FREE_W = $clog2(BUS_FREE_CYC + 1);
  if (BUS_FREE_CYC < 2) $error("bus free timeout too short");
  if (SCL_LOW_CYC >= (1 << TCNT_W) || SCL_HIGH_CYC >= (1 << TCNT_W)) $error("timer too narrow");

  logic [2:0]              scl_s, sda_s;
  logic                    scl_rise, scl_fall, start_det, stop_det;
  logic [FREE_W-1:0]       free_q;
  mstate_e                 mst_q;
  logic [TCNT_W-1:0]       tcnt_q;
  logic                    ms_sda_q, master_q, rw_cmd_q;
  logic [ADDR_BITS-1:0]    addr_cmd_q;
  phase_e                  phase_q;
  logic [3:0]              cnt_q;
  logic                    tx_q, ack_q, byte_drv_q, stop_pend_q, wait_data_q, slv_q;
  logic [DATA_BITS-1:0]    txb_q, rxs_q;
  logic [7:0]              remain_q;
  logic                    accept, arb_hit, nack_ev, stop_fin, fifo_pop, f_valid;
  logic [DATA_BITS-1:0]    f_data;

  // Write data path; draining stalls on an empty FIFO and SCL is held low until a byte arrives
  smbus_fifo #(.W(DATA_BITS), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk      (clk),
    .rst      (rst),
    .in_data  (tx_data),
    .in_valid (tx_valid),
    .in_ready (tx_ready),
    .out_data (f_data),
    .out_valid(f_valid),
    .out_ready(fifo_pop)
  );

  // Two-flop synchronisers plus one history flop for edge finding
  always_ff @(posedge clk) begin
    if (rst) begin
      scl_s <= 3'h7;
      sda_s <= 3'h7;
    end else begin
      scl_s <= {scl_s[1:0], scl_in};
      sda_s <= {sda_s[1:0], sda_in};
    end
  end
  assign scl_rise  = scl_s[1] & ~scl_s[2];
  assign scl_fall  = ~scl_s[1] & scl_s[2];
  assign start_det = scl_s[1] & scl_s[2] & sda_s[2] & ~sda_s[1];
  assign stop_det  = scl_s[1] & scl_s[2] & ~sda_s[2] & sda_s[1];

  // Losing means driving a one (released) and reading zero on a rising edge
  assign arb_hit  = scl_rise && cnt_q < SLOT_ACK && master_q && tx_q && txb_q[~cnt_q[2:0]]
                    && !sda_s[1] && (phase_q == PH_ADDR || phase_q == PH_WRITE);
  assign nack_ev  = scl_fall && cnt_q == SLOT_END && master_q && !ack_q
                    && (phase_q == PH_ADDR || phase_q == PH_WRITE);
  assign accept   = cmd_valid && cmd_ready;
  assign stop_fin = (mst_q == M_STOP_HIGH) && scl_s[1] && tcnt_q == '0;
  assign fifo_pop = wait_data_q && f_valid;

  // Bus busy tracking: set by any START, freed by STOP or long idle high
  always_ff @(posedge clk) begin
    if (rst) begin
      bus_busy <= 1'b0;
      free_q   <= '0;
    end else begin
      free_q <= (scl_s[1] && sda_s[1]) ? ((free_q == FREE_W'(BUS_FREE_CYC)) ? free_q
                                           : free_q + 1'b1) : '0;
      if (start_det) bus_busy <= 1'b1;
      else if (stop_det || free_q == FREE_W'(BUS_FREE_CYC - 1)) bus_busy <= 1'b0;
    end
  end

  // Command acceptance only while idle and the bus is free
  always_ff @(posedge clk) begin
    if (rst) cmd_ready <= 1'b0;
    else cmd_ready <= (mst_q == M_IDLE) && !bus_busy && !start_det && !accept;
  end

  // Master clock generator: START, bit clocking, STOP
  always_ff @(posedge clk) begin
    if (rst) begin
      mst_q      <= M_IDLE;
      tcnt_q     <= '0;
      scl_oe_n   <= 1'b1;
      ms_sda_q   <= 1'b0;
      master_q   <= 1'b0;
      addr_cmd_q <= '0;
      rw_cmd_q   <= DIR_WRITE;
    end else if (arb_hit) begin
      mst_q    <= M_IDLE;
      scl_oe_n <= 1'b1;
      ms_sda_q <= 1'b0;
      master_q <= 1'b0;
    end else begin
      if (tcnt_q != '0) tcnt_q <= tcnt_q - 1'b1;
      case (mst_q)
        M_IDLE: begin
          scl_oe_n <= 1'b1;
          if (accept) begin
            master_q   <= 1'b1;
            addr_cmd_q <= cmd_addr;
            rw_cmd_q   <= cmd_rw;
            ms_sda_q   <= 1'b1;
            tcnt_q     <= TCNT_W'(START_HOLD_CYC);
            mst_q      <= M_START;
          end
        end
        M_START: begin
          if (tcnt_q == '0) begin
            scl_oe_n <= 1'b0;
            tcnt_q   <= TCNT_W'(SCL_LOW_CYC);
            mst_q    <= M_LOW;
          end
        end
        M_LOW: begin
          ms_sda_q <= 1'b0;
          if (tcnt_q == '0 && stop_pend_q) begin
            ms_sda_q <= 1'b1;
            tcnt_q   <= TCNT_W'(SCL_LOW_CYC);
            mst_q    <= M_STOP_LOW;
          end else if (tcnt_q == '0 && !wait_data_q) begin
            scl_oe_n <= 1'b1;
            tcnt_q   <= TCNT_W'(SCL_HIGH_CYC);
            mst_q    <= M_HIGH;
          end
        end
        M_HIGH: begin
          // Timing starts only once SCL is seen high, so a stretching slave wins
          if (!scl_s[1]) tcnt_q <= TCNT_W'(SCL_HIGH_CYC);
          else if (tcnt_q == '0) begin
            scl_oe_n <= 1'b0;
            tcnt_q   <= TCNT_W'(SCL_LOW_CYC);
            mst_q    <= M_LOW;
          end
        end
        M_STOP_LOW: begin
          if (tcnt_q == '0) begin
            scl_oe_n <= 1'b1;
            tcnt_q   <= TCNT_W'(STOP_SETUP_CYC);
            mst_q    <= M_STOP_HIGH;
          end
        end
        M_STOP_HIGH: begin
          if (!scl_s[1]) tcnt_q <= TCNT_W'(STOP_SETUP_CYC);
          else if (tcnt_q == '0) begin
            ms_sda_q <= 1'b0;
            master_q <= 1'b0;
            mst_q    <= M_IDLE;
          end
        end
        default: mst_q <= M_IDLE;
      endcase
    end
  end

  // Byte engine: shifts on SCL edges in both master and slave roles
  always_ff @(posedge clk) begin
    if (rst) begin
      phase_q     <= PH_IDLE;
      cnt_q       <= '0;
      tx_q        <= 1'b0;
      ack_q       <= 1'b0;
      byte_drv_q  <= 1'b0;
      stop_pend_q <= 1'b0;
      wait_data_q <= 1'b0;
      slv_q       <= 1'b0;
      txb_q       <= '0;
      rxs_q       <= '0;
      remain_q    <= '0;
      rx_data     <= '0;
      rx_valid    <= 1'b0;
      rx_as_master <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      if (mst_q == M_STOP_HIGH) stop_pend_q <= 1'b0;
      if (fifo_pop) begin
        txb_q       <= f_data;
        tx_q        <= 1'b1;
        byte_drv_q  <= ~f_data[DATA_BITS-1];
        wait_data_q <= 1'b0;
      end
      if (start_det) begin
        phase_q    <= PH_ADDR;
        cnt_q      <= '0;
        slv_q      <= 1'b0;
        tx_q       <= master_q;
        txb_q      <= {addr_cmd_q, rw_cmd_q};
        remain_q   <= cmd_len;
        byte_drv_q <= 1'b0;
      end else if (stop_det) begin
        phase_q     <= PH_IDLE;
        byte_drv_q  <= 1'b0;
        wait_data_q <= 1'b0;
      end else if (arb_hit) begin
        tx_q       <= 1'b0;
        byte_drv_q <= 1'b0;
        cnt_q      <= cnt_q + 1'b1;
        rxs_q      <= {rxs_q[DATA_BITS-2:0], sda_s[1]};
      end else if (scl_rise && phase_q != PH_IDLE) begin
        if (cnt_q < SLOT_ACK) rxs_q <= {rxs_q[DATA_BITS-2:0], sda_s[1]};
        else ack_q <= ~sda_s[1];
        cnt_q <= (cnt_q == SLOT_ACK) ? SLOT_END : cnt_q + 1'b1;
      end else if (scl_fall && phase_q != PH_IDLE) begin
        if (cnt_q < SLOT_ACK) begin
          byte_drv_q <= tx_q & ~txb_q[~cnt_q[2:0]];
        end else if (cnt_q == SLOT_ACK) begin
          // Acknowledge slot: the receiver of the byte pulls SDA low, except the master on the last read byte
          byte_drv_q <= 1'b0;
          if (phase_q == PH_ADDR && !master_q) begin
            if (rxs_q[DATA_BITS-1:1] == own_addr) begin
              slv_q      <= 1'b1;
              byte_drv_q <= 1'b1;
            end else phase_q <= PH_IDLE;
          end else if (phase_q == PH_WRITE && slv_q) begin
            byte_drv_q <= 1'b1;
            rx_data    <= rxs_q;
            rx_valid   <= 1'b1;
            rx_as_master <= 1'b0;
          end else if (phase_q == PH_READ && master_q) begin
            byte_drv_q <= (remain_q > 8'h01);
            rx_data    <= rxs_q;
            rx_valid   <= 1'b1;
            rx_as_master <= 1'b1;
          end
        end else begin
          // End of byte: choose the next byte's direction or finish
          cnt_q      <= '0;
          byte_drv_q <= 1'b0;
          tx_q       <= 1'b0;
          case (phase_q)
            PH_ADDR: begin
              if (master_q) begin
                if (!ack_q || remain_q == 8'h00) begin
                  stop_pend_q <= 1'b1;
                  phase_q     <= PH_IDLE;
                end else if (txb_q[0] == DIR_READ) begin
                  phase_q <= PH_READ;
                end else begin
                  phase_q     <= PH_WRITE;
                  wait_data_q <= 1'b1;
                end
              end else if (rxs_q[0] == DIR_READ) begin
                phase_q    <= PH_READ;
                tx_q       <= 1'b1;
                txb_q      <= slv_tx_data;
                byte_drv_q <= ~slv_tx_data[DATA_BITS-1];
              end else phase_q <= PH_WRITE;
            end
            PH_WRITE: begin
              if (master_q) begin
                remain_q <= remain_q - 1'b1;
                if (!ack_q || remain_q == 8'h01) begin
                  stop_pend_q <= 1'b1;
                  phase_q     <= PH_IDLE;
                end else wait_data_q <= 1'b1;
              end
            end
            PH_READ: begin
              if (master_q) begin
                remain_q <= remain_q - 1'b1;
                if (remain_q == 8'h01) begin
                  stop_pend_q <= 1'b1;
                  phase_q     <= PH_IDLE;
                end
              end else if (ack_q) begin
                tx_q       <= 1'b1;
                txb_q      <= slv_tx_data;
                byte_drv_q <= ~slv_tx_data[DATA_BITS-1];
              end else phase_q <= PH_IDLE;
            end
            default: phase_q <= PH_IDLE;
          endcase
        end
      end
    end
  end

  // Sticky arb_lost and nack, done a one-cycle pulse; a new event in the clearing cycle wins over the clear
  always_ff @(posedge clk) begin
    if (rst) begin
      arb_lost <= 1'b0;
      nack     <= 1'b0;
      done     <= 1'b0;
    end else begin
      arb_lost <= arb_hit | (arb_lost & ~status_clr);
      nack     <= nack_ev | (nack & ~status_clr);
      done     <= stop_fin;
    end
  end

  // Pin drivers: only ever pull low, enables active low
  always_ff @(posedge clk) begin
    if (rst) begin
      scl_out       <= 1'b0;
      sda_out       <= 1'b0;
      sda_oe_n      <= 1'b1;
      master_active <= 1'b0;
    end else begin
      scl_out       <= 1'b0;
      sda_out       <= 1'b0;
      sda_oe_n      <= ~(byte_drv_q | ms_sda_q) | arb_hit;
      master_active <= master_q;
    end
  end
endmodule

// *** smbus_transaction_engine_test.sv ***
// Self-checking bench for the two-wire transaction engine.
// Assumes the slave in smbus_partner_model.sv and the bound checker.
`timescale 1ns/1ps
module smbus_transaction_engine_test;
  import smbus_pkg::*;
  localparam logic [6:0] PADDR = 7'h2c;
  localparam logic [7:0] PDATA = 8'ha5;
  logic       clk = 1'b0;
  logic       rst;
  logic       scl_out, scl_oe_n, sda_out, sda_oe_n;
  logic       cmd_valid, cmd_ready, cmd_rw, tx_valid, tx_ready, status_clr;
  logic [6:0] cmd_addr;
  logic [7:0] cmd_len, tx_data, rx_data, got_addr, got_data, rx_last, rx_n;
  logic       rx_valid, rx_as_master, bus_busy, master_active, done, arb_lost, nack;
  logic       p_scl, p_sda, stretch, got_mack, rx_m, saw_done;
  logic       scl_w, sda_w, b_sda;
  int         bad_count = 0;
  int         num_checks = 0;

  // Open-drain wires with pull-ups
  assign scl_w = !((!scl_oe_n && !scl_out) || p_scl);
  assign sda_w = !((!sda_oe_n && !sda_out) || p_sda || b_sda);
  always #2.5 clk = ~clk;

  smbus_transaction_engine #(.BUS_FREE_CYC(2000)) u_smbus_transaction_engine (
    .clk(clk), .rst(rst), .scl_in(scl_w), .scl_out(scl_out), .scl_oe_n(scl_oe_n),
    .sda_in(sda_w), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_addr(cmd_addr), .cmd_rw(cmd_rw), .cmd_len(cmd_len),
    .tx_data(tx_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .own_addr(7'h51),
    .slv_tx_data(8'h3c), .rx_data(rx_data), .rx_valid(rx_valid),
    .rx_as_master(rx_as_master), .bus_busy(bus_busy), .master_active(master_active),
    .done(done), .arb_lost(arb_lost), .nack(nack), .status_clr(status_clr));

  smbus_partner_model #(.ADDR(PADDR), .DATA(PDATA)) u_smbus_partner_model (
    .scl(scl_w), .sda(sda_w), .stretch(stretch), .scl_pull(p_scl), .sda_pull(p_sda),
    .got_addr(got_addr), .got_data(got_data), .got_mack(got_mack));

  // Receive strobe lasts one cycle, so latch it here
  always @(posedge clk) if (rx_valid === 1'b1) begin
    rx_last <= rx_data;
    rx_m <= rx_as_master;
    rx_n <= rx_n + 8'h01;
  end

  task automatic tick();
    @(posedge clk);
    #1;
  endtask
  task automatic chk_bit(input string what, input logic exp, input logic got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic chk_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic stop_test();
    if (bad_count == 0 && num_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic give_up(input string what);
    bad_count++;
    $display("unexpected %s: expected end seen timeout", what);
    stop_test();
  endtask
  task automatic wait_ready();
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 20000) begin tick(); n++; end
    if (n >= 20000) give_up("cmd_ready");
  endtask
  // One master command; waits for done, nack or arbitration loss
  task automatic run_cmd(input logic [6:0] a, input logic rw, input logic [7:0] len);
    int n;
    wait_ready();
    cmd_addr = a;
    cmd_rw = rw;
    cmd_len = len;
    cmd_valid = 1'b1;
    tick();
    cmd_valid = 1'b0;
    saw_done = 1'b0;
    n = 0;
    while (!(saw_done || nack === 1'b1 || arb_lost === 1'b1) && n < 60000) begin
      tick();
      n++;
      if (done === 1'b1) saw_done = 1'b1;
    end
    if (n >= 60000) give_up("command end");
  endtask

  // Push 16 bytes into the FIFO, check it refuses more, then write its head byte
  task automatic t_fill_write();
    int n;
    n = 0;
    while (tx_ready !== 1'b1 && n < 100) begin tick(); n++; end
    if (n >= 100) give_up("tx_ready");
    for (int i = 0; i < 16; i++) begin
      tx_data = 8'h10 + 8'(i);
      tx_valid = 1'b1;
      tick();
    end
    tx_valid = 1'b0;
    chk_bit("tx_ready full", 1'b0, tx_ready);
    run_cmd(PADDR, DIR_WRITE, 8'h01);
    chk_bit("done", 1'b1, saw_done);
    chk_bit("nack", 1'b0, nack);
    chk_byte("address byte", {PADDR, DIR_WRITE}, got_addr);
    chk_byte("written byte", 8'h10, got_data);
    chk_bit("tx_ready after pop", 1'b1, tx_ready);
  endtask
  // Read one byte while the slave stretches every clock low
  task automatic t_read_stretch();
    stretch = 1'b1;
    run_cmd(PADDR, DIR_READ, 8'h01);
    stretch = 1'b0;
    chk_bit("done", 1'b1, saw_done);
    chk_byte("address byte", {PADDR, DIR_READ}, got_addr);
    chk_byte("read byte", PDATA, rx_last);
    chk_byte("read count", 8'h01, rx_n);
    chk_bit("rx_as_master", 1'b1, rx_m);
    chk_bit("last byte refused", 1'b1, got_mack);
  endtask
  // Nobody answers the address: sticky flag, then cleared
  task automatic t_addr_nack();
    run_cmd(7'h13, DIR_WRITE, 8'h00);
    chk_bit("nack", 1'b1, nack);
    chk_bit("arb_lost", 1'b0, arb_lost);
    status_clr = 1'b1;
    tick();
    status_clr = 1'b0;
    tick();
    chk_bit("nack cleared", 1'b0, nack);
    wait_ready();
    chk_bit("bus_busy", 1'b0, bus_busy);
  endtask
  // A rival pulls SDA low under our first address one: we must yield the bus
  task automatic t_arb_loss();
    int n;
    n = 0;
    fork
      run_cmd(7'h40, DIR_WRITE, 8'h01);
      begin
        while (scl_oe_n !== 1'b0 && n < 5000) begin tick(); n++; end
        if (n >= 5000) give_up("scl low");
        b_sda = 1'b1;
      end
    join
    b_sda = 1'b0;  // Rival lets SDA rise with SCL high, a STOP
    tick();
    tick();
    chk_bit("arb_lost", 1'b1, arb_lost);
    chk_bit("master_active", 1'b0, master_active);
    chk_bit("scl_oe_n", 1'b1, scl_oe_n);
    chk_bit("sda_oe_n", 1'b1, sda_oe_n);
    chk_bit("sda_out", 1'b0, sda_out);
    chk_bit("scl_out", 1'b0, scl_out);
    chk_bit("done", 1'b0, saw_done);
    status_clr = 1'b1;
    tick();
    status_clr = 1'b0;
    tick();
    chk_bit("arb_lost cleared", 1'b0, arb_lost);
    wait_ready();
    chk_bit("bus_busy", 1'b0, bus_busy);
  endtask

  initial begin
    rst = 1'b1;
    {cmd_valid, cmd_rw, tx_valid, status_clr, stretch, b_sda} = 6'h00;
    {cmd_addr, cmd_len, tx_data, rx_n} = 31'h0;
    repeat (16) @(posedge clk);
    #1;
    rst = 1'b0;
    t_fill_write();
    t_read_stretch();
    t_addr_nack();
    t_arb_loss();
    stop_test();
  end
endmodule
